// File: src/brw_pkg.sv
package brw_pkg;

    // register offsets on the avalon slave (byte addresses)
    localparam logic [3:0]  OFS_LEVELS      = 4'h0;
    localparam logic [3:0]  OFS_STATUS      = 4'h4;
    localparam logic [3:0]  OFS_WDOG        = 4'h8;

    // levels register fields
    localparam int          LVL_W           = 2;
    localparam int          POS_CORE_INT    = 0;
    localparam int          POS_IO_INT      = 2;
    localparam int          POS_CORE_RST    = 4;
    localparam logic [1:0]  LVL_RESET_VAL   = 2'h0;

    // status register fields, flags are write-one-to-clear
    localparam int          POS_CORE_FLAG   = 0;
    localparam int          POS_IO_FLAG     = 1;
    localparam int          POS_WD_FLAG     = 2;
    localparam int          POS_RUNNING     = 3;
    localparam int          POS_WD_RSTCNT   = 4;

    // watchdog control register fields
    localparam int          POS_WD_EN       = 0;
    localparam int          POS_WD_SEL      = 1;
    localparam int          POS_WD_KICK     = 3;
    localparam logic [1:0]  WD_SEL_RESET    = 2'h0;
    localparam logic        WD_EN_RESET     = 1'b0;

    // clock rates and times
    localparam int          MCLK_KHZ        = 100000;
    localparam int          RC_KHZ          = 7600;
    localparam int          PWRUP_US        = 8600;
    localparam int          PWRUP_TICKS     = RC_KHZ * PWRUP_US / 1000;
    localparam int          WD_BASE_EXP     = 12;
    localparam int          WD_EXP_STEP     = 3;
    localparam int          WD_RST_TICKS    = 512;

    // reset vector handed to the core
    localparam logic [15:0] RESET_VECTOR    = 16'h8000;

    // supply sequencing states
    typedef enum logic [2:0] {
        ST_POR,
        ST_PWRUP,
        ST_RUN,
        ST_BOR,
        ST_WDRST
    } brw_state_t;

endpackage

// File: src/brw_sync.sv
// two-flop synchroniser for asynchronous levels
module brw_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] stage1;      // first stage, read only by stage two
    logic [W-1:0] next_stage1; // next value of stage one
    logic [W-1:0] next_out;    // next value of output stage

    // capture path
    always_comb begin
        next_stage1 = async_in;
        next_out    = stage1;
    end

    // register both stages
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= next_stage1;
            sync_out <= next_out;
        end
    end

endmodule

// File: src/brw_top.sv
// Contract
// - bo interrupt when supply under level
// - drive reset low above one volt
// - power-on level loads all defaults
// - core reset level clears to 00
// - release after 8.6 ms rc count
// - execution starts at vector 8000h
// - core brownout asserts reset, defaults most
// - brownout keeps core reset level
// - reset held while below brownout level
// - recovery from brownout skips counter
// - below power-on level restarts full sequence
// - watchdog clocked by rc divider chain
// - timeout sets flag and interrupt
// - default timeout is 2^12 rc cycles
// - reset 512 rc cycles after timeout
// - any reset restores default ratio; a reset held on the pin keeps the ratio
// - two-bit select picks longer periods
// - select change before timeout clears count
module brw_top
    import brw_pkg::*;
#(
    parameter int PWRUP_CNT = PWRUP_TICKS, // rc ticks before release
    parameter int WD_EXP0   = WD_BASE_EXP  // log2 of default timeout
) (
    input  wire logic        mclk,
    input  wire logic        nrst,
    // avalon-mm slave
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // supply comparators, asynchronous
    input  wire logic        core_above_1v0,
    input  wire logic        core_above_por,
    input  wire logic        core_above_bor,
    input  wire logic        core_below_int,
    input  wire logic        io_below_int,
    // threshold selections to the comparators
    output logic      [1:0]  core_bo_int_level,
    output logic      [1:0]  io_bo_int_level,
    output logic      [1:0]  core_bo_reset_level,
    // open-drain reset pin
    input  wire logic        rst_pin_i,
    output logic             rst_pin_o,
    output logic             rst_pin_oe_n,
    // to the processor core
    output logic             core_reset_n,
    output logic      [15:0] reset_vector,
    output logic             core_bo_irq,
    output logic             io_bo_irq,
    output logic             wdog_irq
);

    localparam int WD_W = 32;              // watchdog count width
    localparam int PU_W = $clog2(PWRUP_CNT + 1);

    // synchronised inputs
    logic [5:0] sync_v;
    logic       s_1v0;
    logic       s_por;
    logic       s_bor;
    logic       s_core_low;
    logic       s_io_low;
    logic       s_pin;

    brw_sync #(
        .W(6)
    ) u_sync (
        .mclk    (mclk),
        .nrst    (nrst),
        .async_in({rst_pin_i, io_below_int, core_below_int,
                   core_above_bor, core_above_por, core_above_1v0}),
        .sync_out(sync_v)
    );

    // unpack synchronised levels
    assign s_1v0      = sync_v[0];
    assign s_por      = sync_v[1];
    assign s_bor      = sync_v[2];
    assign s_core_low = sync_v[3];
    assign s_io_low   = sync_v[4];
    assign s_pin      = sync_v[5];

    // fast rc tick from a fractional divider
    logic [16:0] rc_acc;      // phase accumulator
    logic [16:0] next_rc_acc; // next phase
    logic        rc_tick;     // one-cycle rc enable
    logic        next_rc_tick;

    // add rc rate each cycle, wrap at mclk rate
    always_comb begin
        if (rc_acc + 17'(RC_KHZ) >= 17'(MCLK_KHZ)) begin
            next_rc_acc  = 17'(rc_acc + 17'(RC_KHZ) - 17'(MCLK_KHZ));
            next_rc_tick = 1'b1;
        end else begin
            next_rc_acc  = 17'(rc_acc + 17'(RC_KHZ));
            next_rc_tick = 1'b0;
        end
    end

    // register the divider
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rc_acc  <= '0;
            rc_tick <= 1'b0;
        end else begin
            rc_acc  <= next_rc_acc;
            rc_tick <= next_rc_tick;
        end
    end

    // sequencing state
    brw_state_t  state;       // current state
    brw_state_t  next_state;  // next state
    logic [PU_W-1:0] pu_cnt;  // power-up counter
    logic [PU_W-1:0] next_pu_cnt;
    logic        wd_fire;     // watchdog reset request

    // supply supervisor
    always_comb begin
        next_state  = state;
        next_pu_cnt = pu_cnt;
        case (state)
            ST_POR: begin
                next_pu_cnt = '0;
                if (s_por && s_bor) begin
                    next_state = ST_PWRUP;
                end
            end
            ST_PWRUP: begin
                if (!s_bor) begin
                    next_state = ST_POR;
                end else if (rc_tick) begin
                    if (pu_cnt == PU_W'(PWRUP_CNT - 1)) begin
                        next_state = ST_RUN;
                    end else begin
                        next_pu_cnt = PU_W'(pu_cnt + 1'b1);
                    end
                end
            end
            ST_RUN: begin
                if (!s_bor) begin
                    next_state = ST_BOR;
                end else if (wd_fire) begin
                    next_state = ST_WDRST;
                end
            end
            ST_BOR: begin
                if (s_bor) begin
                    next_state = ST_RUN;
                end
            end
            ST_WDRST: begin
                next_state = s_bor ? ST_RUN : ST_BOR;
            end
            default: begin
                next_state = ST_POR;
            end
        endcase
        // losing the power-on level overrides all
        if (!s_por) begin
            next_state = ST_POR;
        end
    end

    // register supervisor state
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state  <= ST_POR;
            pu_cnt <= '0;
        end else begin
            state  <= next_state;
            pu_cnt <= next_pu_cnt;
        end
    end

    logic por_clr; // power-on defaults
    logic any_clr; // any supervisor reset in force (not a pin-held reset)
    assign por_clr = (state == ST_POR);
    assign any_clr = (state != ST_RUN);

    // reset pin, core reset and vector
    logic next_pin_oe_n;
    logic next_core_reset_n;

    // drive the pin low once supply is up and not running
    always_comb begin
        next_pin_oe_n     = !(s_1v0 && any_clr);
        next_core_reset_n = !any_clr && s_pin;
    end

    // register pin and core reset
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rst_pin_o    <= 1'b0;
            rst_pin_oe_n <= 1'b1;
            core_reset_n <= 1'b0;
            reset_vector <= RESET_VECTOR;
        end else begin
            rst_pin_o    <= 1'b0;
            rst_pin_oe_n <= next_pin_oe_n;
            core_reset_n <= next_core_reset_n;
            reset_vector <= RESET_VECTOR;
        end
    end

    // bus decode
    logic acc_wr;   // write taken this edge
    logic acc_rd;   // read answered
    logic wr_lvl;
    logic wr_stat;
    logic wr_wd;
    assign acc_wr  = write && !waitrequest;
    assign acc_rd  = read && waitrequest;
    assign wr_lvl  = acc_wr && (address == OFS_LEVELS);
    assign wr_stat = acc_wr && (address == OFS_STATUS);
    assign wr_wd   = acc_wr && (address == OFS_WDOG);

    // threshold levels
    logic [1:0] next_core_int;
    logic [1:0] next_io_int;
    logic [1:0] next_core_rst;

    // software writes levels only while running
    always_comb begin
        next_core_int = core_bo_int_level;
        next_io_int   = io_bo_int_level;
        next_core_rst = core_bo_reset_level;
        if (por_clr) begin
            next_core_int = LVL_RESET_VAL;
            next_io_int   = LVL_RESET_VAL;
            next_core_rst = LVL_RESET_VAL;
        end else if (any_clr) begin
            next_core_int = LVL_RESET_VAL;
            next_io_int   = LVL_RESET_VAL;
            // reset level kept through brownout
        end else if (wr_lvl) begin
            next_core_int = writedata[POS_CORE_INT +: LVL_W];
            next_io_int   = writedata[POS_IO_INT +: LVL_W];
            next_core_rst = writedata[POS_CORE_RST +: LVL_W];
        end
    end

    // register levels
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            core_bo_int_level   <= LVL_RESET_VAL;
            io_bo_int_level     <= LVL_RESET_VAL;
            core_bo_reset_level <= LVL_RESET_VAL;
        end else begin
            core_bo_int_level   <= next_core_int;
            io_bo_int_level     <= next_io_int;
            core_bo_reset_level <= next_core_rst;
        end
    end

    // watchdog
    logic              wd_en;       // enable bit
    logic [1:0]        wd_sel;      // ratio select
    logic [WD_W-1:0]   wd_cnt;      // interrupt count
    logic              wd_rst_run;  // reset delay counting
    logic [9:0]        wd_rcnt;     // reset delay count
    logic              wd_flag;     // timeout flag
    logic              next_wd_en;
    logic [1:0]        next_wd_sel;
    logic [WD_W-1:0]   next_wd_cnt;
    logic              next_wd_rst_run;
    logic [9:0]        next_wd_rcnt;
    logic              next_wd_fire;
    logic [WD_W-1:0]   wd_limit;    // selected timeout
    logic [1:0]        new_sel;

    // timeout length from select, longer for higher values
    assign wd_limit = WD_W'(1) << (WD_EXP0 + WD_EXP_STEP * int'(wd_sel));
    assign new_sel  = writedata[POS_WD_SEL +: 2];

    // watchdog counters
    always_comb begin
        next_wd_en      = wd_en;
        next_wd_sel     = wd_sel;
        next_wd_cnt     = wd_cnt;
        next_wd_rst_run = wd_rst_run;
        next_wd_rcnt    = wd_rcnt;
        next_wd_fire    = 1'b0;
        if (any_clr) begin
            next_wd_en      = WD_EN_RESET;
            next_wd_sel     = WD_SEL_RESET;
            next_wd_cnt     = '0;
            next_wd_rst_run = 1'b0;
            next_wd_rcnt    = '0;
        end else if (wr_wd) begin
            next_wd_en  = writedata[POS_WD_EN];
            next_wd_sel = new_sel;
            if (new_sel != wd_sel && !wd_rst_run) begin
                next_wd_cnt = '0;
            end
            if (writedata[POS_WD_KICK]) begin
                next_wd_cnt     = '0;
                next_wd_rst_run = 1'b0;
                next_wd_rcnt    = '0;
            end
        end else if (wd_en && rc_tick) begin
            if (wd_rst_run) begin
                if (wd_rcnt == 10'(WD_RST_TICKS - 1)) begin
                    next_wd_fire = 1'b1;
                end else begin
                    next_wd_rcnt = 10'(wd_rcnt + 1'b1);
                end
            end else if (wd_cnt == wd_limit - 1'b1) begin
                next_wd_cnt     = '0;
                next_wd_rst_run = 1'b1;
            end else begin
                next_wd_cnt = WD_W'(wd_cnt + 1'b1);
            end
        end
    end

    // register watchdog
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wd_en      <= WD_EN_RESET;
            wd_sel     <= WD_SEL_RESET;
            wd_cnt     <= '0;
            wd_rst_run <= 1'b0;
            wd_rcnt    <= '0;
            wd_fire    <= 1'b0;
        end else begin
            wd_en      <= next_wd_en;
            wd_sel     <= next_wd_sel;
            wd_cnt     <= next_wd_cnt;
            wd_rst_run <= next_wd_rst_run;
            wd_rcnt    <= next_wd_rcnt;
            wd_fire    <= next_wd_fire;
        end
    end

    // sticky flags
    logic       wd_set;     // timeout event
    logic       next_core_flag;
    logic       next_io_flag;
    logic       next_wd_flag;
    assign wd_set = !wd_rst_run && next_wd_rst_run && !any_clr;

    // set beats write-one clear
    always_comb begin
        next_core_flag = core_bo_irq;
        next_io_flag   = io_bo_irq;
        next_wd_flag   = wd_flag;
        if (any_clr) begin
            next_core_flag = 1'b0;
            next_io_flag   = 1'b0;
            next_wd_flag   = 1'b0;
        end else begin
            if (wr_stat && writedata[POS_CORE_FLAG]) begin
                next_core_flag = 1'b0;
            end
            if (wr_stat && writedata[POS_IO_FLAG]) begin
                next_io_flag = 1'b0;
            end
            if (wr_stat && writedata[POS_WD_FLAG]) begin
                next_wd_flag = 1'b0;
            end
            if (s_core_low) begin
                next_core_flag = 1'b1;
            end
            if (s_io_low) begin
                next_io_flag = 1'b1;
            end
            if (wd_set) begin
                next_wd_flag = 1'b1;
            end
        end
    end

    // register flags, which are also the interrupts
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            core_bo_irq <= 1'b0;
            io_bo_irq   <= 1'b0;
            wd_flag     <= 1'b0;
            wdog_irq    <= 1'b0;
        end else begin
            core_bo_irq <= next_core_flag;
            io_bo_irq   <= next_io_flag;
            wd_flag     <= next_wd_flag;
            wdog_irq    <= next_wd_flag;
        end
    end

    // bus answer: one wait state, then waitrequest low
    logic [31:0] next_readdata;
    logic        next_wait;

    always_comb begin
        next_readdata = readdata;
        next_wait     = 1'b1;
        if ((read || write) && waitrequest) begin
            next_wait = 1'b0;
        end
        if (acc_rd) begin
            next_readdata = '0;
            case (address)
                OFS_LEVELS: begin
                    next_readdata[POS_CORE_INT +: LVL_W] = core_bo_int_level;
                    next_readdata[POS_IO_INT +: LVL_W]   = io_bo_int_level;
                    next_readdata[POS_CORE_RST +: LVL_W] = core_bo_reset_level;
                end
                OFS_STATUS: begin
                    next_readdata[POS_CORE_FLAG] = core_bo_irq;
                    next_readdata[POS_IO_FLAG]   = io_bo_irq;
                    next_readdata[POS_WD_FLAG]   = wd_flag;
                    next_readdata[POS_RUNNING]   = (state == ST_RUN);
                    next_readdata[POS_WD_RSTCNT] = wd_rst_run;
                end
                OFS_WDOG: begin
                    next_readdata[POS_WD_EN]       = wd_en;
                    next_readdata[POS_WD_SEL +: 2] = wd_sel;
                end
                default: begin
                    next_readdata = '0; // unmapped reads zero
                end
            endcase
        end
    end

    // register bus outputs
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            readdata    <= '0;
            waitrequest <= 1'b1;
        end else begin
            readdata    <= next_readdata;
            waitrequest <= next_wait;
        end
    end

endmodule

// File: tb/brw_top_props.sv
module brw_top_props
    import brw_pkg::*;
(
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic [3:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic        waitrequest,
    input wire logic        core_above_1v0,
    input wire logic        core_above_por,
    input wire logic        core_above_bor,
    input wire logic        core_below_int,
    input wire logic        io_below_int,
    input wire logic [1:0]  core_bo_reset_level,
    input wire logic        rst_pin_i,
    input wire logic        rst_pin_o,
    input wire logic        rst_pin_oe_n,
    input wire logic        core_reset_n,
    input wire logic [15:0] reset_vector,
    input wire logic        core_bo_irq,
    input wire logic        io_bo_irq
);
    logic lvl_wr;   // levels write lands at this edge
    logic clr_core; // core flag clear lands at this edge
    assign lvl_wr = write && !waitrequest && address == OFS_LEVELS;
    assign clr_core = write && !waitrequest && address == OFS_STATUS && writedata[POS_CORE_FLAG];
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    // one answer cycle, then idle again
    sequence s_answer;
        !waitrequest ##1 waitrequest;
    endsequence
    // core enters reset shortly
    sequence s_held;
        ##[0:2] !core_reset_n;
    endsequence
    chk_bus_answer: assert property ((read || write) && waitrequest |=> s_answer)
        else $error("bus answer not one cycle");
    chk_vector_fixed: assert property (reset_vector == RESET_VECTOR)
        else $error("reset vector wrong");
    chk_pin_drive: assert property (!rst_pin_oe_n |-> !rst_pin_o)
        else $error("reset pin driven high");
    chk_pin_low: assert property ((core_above_1v0 && !core_above_bor)[*5] |-> !rst_pin_oe_n)
        else $error("reset pin not pulled low");
    chk_core_held: assert property ((!core_above_bor)[*6] |-> !core_reset_n)
        else $error("core out of reset in brownout");
    chk_ext_hold: assert property ((!rst_pin_i)[*5] |-> !core_reset_n)
        else $error("core runs while pin held low");
    chk_irq_core: assert property ((core_below_int && core_reset_n)[*5] |-> core_bo_irq)
        else $error("core brownout flag missing");
    chk_irq_io: assert property ((io_below_int && core_reset_n)[*5] |-> io_bo_irq)
        else $error("io brownout flag missing");
    chk_sync_delay: assert property ($rose(core_below_int) && !core_bo_irq |=> !core_bo_irq)
        else $error("flag set without synchroniser");
    chk_flag_sticky: assert property ($fell(core_bo_irq) |-> $past(clr_core) or s_held)
        else $error("flag dropped on its own");
    chk_level_kept: assert property (core_above_por[*4] ##0 $changed(core_bo_reset_level) |-> $past(lvl_wr))
        else $error("reset level changed without write");
    chk_por_clear: assert property ((!core_above_por)[*5] |-> core_bo_reset_level == LVL_RESET_VAL)
        else $error("reset level not cleared");
    chk_run_free: assert property (core_reset_n |-> rst_pin_oe_n)
        else $error("pin pulled while core runs");
endmodule

bind brw_top brw_top_props brw_top_props_i (.*);

// File: tb/brw_supply_model.sv
module brw_supply_model #(
    parameter int BOR_MV0  = 2700, // lowest brownout reset level, mV
    parameter int CINT_MV0 = 3050, // lowest core interrupt level, mV
    parameter int IINT_MV0 = 4500  // lowest io interrupt level, mV
) (
    input  wire logic [15:0] core_mv,
    input  wire logic [15:0] io_mv,
    input  wire logic        ext_hold,
    input  wire logic [1:0]  core_bo_int_level,
    input  wire logic [1:0]  io_bo_int_level,
    input  wire logic [1:0]  core_bo_reset_level,
    input  wire logic        rst_pin_o,
    input  wire logic        rst_pin_oe_n,
    output logic             core_above_1v0,
    output logic             core_above_por,
    output logic             core_above_bor,
    output logic             core_below_int,
    output logic             io_below_int,
    output logic             rst_pin_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // comparators follow the supplies and the selected levels
    always_comb begin
        core_above_1v0 = core_mv > 16'h03E8;
        core_above_por = core_mv > 16'h04B0;
        core_above_bor = int'(core_mv) > BOR_MV0 + 100 * int'(core_bo_reset_level);
        core_below_int = int'(core_mv) < CINT_MV0 + 50 * int'(core_bo_int_level);
        io_below_int = int'(io_mv) < IINT_MV0 + 100 * int'(io_bo_int_level);
        rst_pin_i = (rst_pin_oe_n || rst_pin_o) && !ext_hold; // pulled up unless pulled low
    end
endmodule

// File: tb/brw_top_bench.sv
module brw_top_bench;
    import brw_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PW = 4;              // shortened power-up count
    localparam int WE = 2;              // shortened watchdog exponent
    localparam logic [15:0] OK = 16'h0CE4; // healthy core supply, mV
    localparam logic [15:0] IO = 16'h1388; // healthy io supply, mV
    logic        mclk, nrst, read, write, waitrequest, ext_hold, rst_pin_i, rst_pin_o, rst_pin_oe_n;
    logic        core_above_1v0, core_above_por, core_above_bor, core_below_int, io_below_int;
    logic        core_reset_n, core_bo_irq, io_bo_irq, wdog_irq;
    logic [1:0]  core_bo_int_level, io_bo_int_level, core_bo_reset_level;
    logic [3:0]  address;
    logic [15:0] core_mv, io_mv, reset_vector;
    logic [31:0] writedata, readdata, q, lf;
    int          err_count, cmp_count, n, e, s;

    brw_top #(.PWRUP_CNT(PW), .WD_EXP0(WE)) brw_top_i (.*);
    brw_supply_model brw_supply_model_i (.*);

    // free-running system clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // pseudo-random source
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // rc ticks expressed in system clocks
    function automatic int cyc(input int t);
        return t * (MCLK_KHZ / 100) / (RC_KHZ / 100);
    endfunction
    task automatic wrap_up();
        $display("mismatches %0d of %0d compares", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
            err_count++;
        end
    endtask
    // count within a tolerance window
    task automatic near(input int got, input int want);
        check(32'(got >= want - 20 && got <= want + 20), 32'h1);
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge mclk);
    endtask
    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge mclk);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (k >= 50) begin
            err_count++;
            wrap_up();
        end
    endtask
    // bounded wait for core reset (which 0) or watchdog flag (which 1)
    task automatic wait_for(input logic which, input logic lvl, input int max);
        n = 0;
        while ((which ? wdog_irq : core_reset_n) !== lvl && n < max) begin
            @(posedge mclk);
            n++;
        end
        if (n >= max) begin
            err_count++;
            wrap_up();
        end
    endtask
    task automatic supply(input logic [15:0] c, input logic [15:0] i);
        @(posedge mclk);
        core_mv <= c;
        io_mv <= i;
    endtask

    // main sequence
    initial begin
        nrst = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 4'h0;
        writedata = 32'h0;
        core_mv = 16'h0000;
        io_mv = IO;
        ext_hold = 1'b0;
        err_count = 0;
        cmp_count = 0;
        lf = 32'h0682461B;
        idle(5);
        nrst <= 1'b1;
        supply(16'h044C, IO); // above one volt only
        idle(8);
        check(32'(rst_pin_oe_n), 32'h0);
        supply(OK, IO); // full power-up
        wait_for(1'b0, 1'b1, 300);
        near(n, cyc(PW) + 4);
        check(32'(reset_vector), 32'h8000);
        bus(1'b0, OFS_LEVELS, 32'h0);
        check(q, 32'h0);
        bus(1'b0, OFS_WDOG, 32'h0);
        check(q, 32'h0);
        bus(1'b1, 4'hC, 32'hFFFFFFFF); // unmapped place
        bus(1'b0, 4'hC, 32'h0);
        check(q, 32'h0);
        lf = lfsr_next(lf);
        bus(1'b1, OFS_LEVELS, {26'h0, 2'h1, lf[3:0]});
        bus(1'b0, OFS_LEVELS, 32'h0);
        check(q, {26'h0, 2'h1, lf[3:0]});
        check(32'({core_bo_int_level, io_bo_int_level}), 32'({lf[1:0], lf[3:2]}));
        supply(16'h0B86, 16'h1130); // both supplies under their interrupt levels
        idle(10);
        check(32'({io_bo_irq, core_bo_irq}), 32'h3);
        supply(OK, IO);
        idle(10);
        check(32'({io_bo_irq, core_bo_irq}), 32'h3);
        bus(1'b1, OFS_STATUS, 32'h3);
        bus(1'b0, OFS_STATUS, 32'h0);
        check(q & 32'hF, 32'h8);
        ext_hold <= 1'b1; // pin held from outside
        idle(10);
        check(32'(core_reset_n), 32'h0);
        ext_hold <= 1'b0;
        wait_for(1'b0, 1'b1, 20);
        supply(16'h0A8C, IO); // brownout, above power-on level
        idle(40);
        check(32'({core_reset_n, rst_pin_oe_n}), 32'h0);
        supply(OK, IO);
        wait_for(1'b0, 1'b1, 20); // no counter delay
        check(32'(n < cyc(PW) - 20), 32'h1);
        bus(1'b0, OFS_LEVELS, 32'h0);
        check(q, 32'h10);
        supply(16'h0320, IO); // below power-on level
        idle(10);
        supply(OK, IO);
        wait_for(1'b0, 1'b1, 300);
        near(n, cyc(PW) + 4);
        bus(1'b0, OFS_LEVELS, 32'h0);
        check(q, 32'h0);
        for (s = 0; s < 4; s++) begin
            bus(1'b1, OFS_WDOG, 32'(s * 2 + 1));
            wait_for(1'b1, 1'b1, 30000);
            near(n, cyc(1 << (WE + 3 * s)));
            wait_for(1'b0, 1'b0, 8000);
            near(n, cyc(WD_RST_TICKS));
            wait_for(1'b0, 1'b1, 50);
            bus(1'b0, OFS_WDOG, 32'h0);
            check(q, 32'h0);
        end
        bus(1'b1, OFS_WDOG, 32'h3);
        idle(250);
        bus(1'b1, OFS_WDOG, 32'h1); // select changed before timeout
        wait_for(1'b1, 1'b1, 500);
        near(n, cyc(1 << WE));
        wait_for(1'b0, 1'b0, 8000);
        wait_for(1'b0, 1'b1, 50);
        bus(1'b1, OFS_WDOG, 32'h1);
        repeat (6) begin
            idle(30);
            bus(1'b1, OFS_WDOG, 32'h9);
        end
        check(32'(wdog_irq), 32'h0);
        wrap_up();
    end
endmodule
